// ---- rtl/sync_burst_sram_cmd_port.sv ----
// Command-side port of a synchronous pipelined burst memory
//
// Overview of operation
// - Address pins, low two bits included, are taken on a rising edge.
// - Lane write selects count only in write cycles, begun by a load with an active write strobe.
// - Each lane select gates its data byte and its parity bit alike.
// - The write strobe is sampled only on edges with the qualifier low.
// - Advance high on a qualified edge steps the burst counter of a live read or write burst.
// - With the qualifier high all command and burst state holds and selection stays.
// - Selection needs select one low, select two high, select three low.
// - The burst order strap picks interleaved when high, linear when low.
// - Data drivers stay off in write data, after deselect and deselected.
`timescale 1ns/10ps
`default_nettype none

module sync_burst_sram_cmd_port (
   input  wire logic                               clock,
   input  wire logic                               rst,
   input  wire logic [sram_cmd_pkg::UPPER_W-1:0]   addr_high,
   input  wire logic                               addr_bit_one,
   input  wire logic                               addr_bit_zero,
   input  wire logic                               write_strobe_n,
   input  wire logic [sram_cmd_pkg::LANES-1:0]     lane_write_select_n,
   input  wire logic                               advance_or_load,
   input  wire logic                               clock_qualifier_n,
   input  wire logic                               chip_select_one_n,
   input  wire logic                               chip_select_two,
   input  wire logic                               chip_select_three_n,
   input  wire logic                               output_enable_n,
   input  wire logic                               burst_order_strap,
   input  wire logic [sram_cmd_pkg::DATA_W-1:0]    dq_in,
   input  wire logic [sram_cmd_pkg::LANES-1:0]     parity_lane_in,
   output logic      [sram_cmd_pkg::DATA_W-1:0]    dq_out,
   output logic      [sram_cmd_pkg::LANES-1:0]     parity_lane_out,
   output logic                                    dq_oe,
   input  wire logic                               rsp_valid,
   input  wire logic [sram_cmd_pkg::DATA_W-1:0]    rsp_data,
   input  wire logic [sram_cmd_pkg::LANES-1:0]     rsp_parity,
   output var  logic                               acc_valid,
   input  wire logic                               acc_ready,
   output var  sram_cmd_pkg::access_s              acc_word,
   output var  logic                               cmd_ready
);

   localparam int ACC_W = $bits(sram_cmd_pkg::access_s);

   // ***************************************************************
   // State
   // ***************************************************************
   sram_cmd_pkg::access_state_e             state_q, state_d;
   logic [sram_cmd_pkg::UPPER_W-1:0]        upper_q, upper_d;
   logic [sram_cmd_pkg::LOW_W-1:0]          start_q, start_d;
   logic [sram_cmd_pkg::LOW_W-1:0]          cnt_q, cnt_d;
   logic                                    order_q;
   sram_cmd_pkg::access_s                   stage_q, stage_d;
   logic                                    stage_valid_q, stage_valid_d;
   logic                                    read_window_q, read_window_d;
   logic [ACC_W-1:0]                        buf_out;

   // ***************************************************************
   // Pin decode
   // ***************************************************************
   logic                                    qual;
   logic                                    selected;
   logic                                    do_load;
   logic                                    do_adv;
   logic                                    beat;
   sram_cmd_pkg::access_state_e             new_state;
   logic                                    is_write;
   logic [sram_cmd_pkg::LOW_W-1:0]          beat_low;
   logic [sram_cmd_pkg::LOW_W-1:0]          pin_low;
   logic                                    push;
   logic                                    buf_ready;
   sram_cmd_pkg::access_s                   push_word;

   // Edges with the qualifier high are invisible to all command and burst state
   assign qual     = ~clock_qualifier_n;
   assign selected = ~chip_select_one_n & chip_select_two
                     & ~chip_select_three_n;
   assign pin_low  = {addr_bit_one, addr_bit_zero};
   assign do_load  = qual & ~advance_or_load;
   // An advance after deselect has no burst to continue and is dropped
   assign do_adv   = qual & advance_or_load
                     & (state_q != sram_cmd_pkg::st_idle);
   assign new_state = ~selected ? sram_cmd_pkg::st_idle :
                      ~write_strobe_n ? sram_cmd_pkg::st_write :
                      sram_cmd_pkg::st_read;

   // ***************************************************************
   // Next-state terms
   // ***************************************************************
   // Load takes the pins; advance keeps the loaded upper bits
   assign state_d = do_load ? new_state : state_q;
   assign upper_d = do_load ? addr_high : upper_q;
   assign start_d = do_load ? pin_low : start_q;
   assign cnt_d   = do_load ? sram_cmd_pkg::CNT_ZERO :
                    do_adv  ? cnt_q + sram_cmd_pkg::CNT_STEP :
                    cnt_q;
   // Interleaved order flips bits, linear order adds with wrap
   assign beat_low = (order_q == sram_cmd_pkg::ORDER_INTERLEAVED) ?
                     (start_d ^ cnt_d) : (start_d + cnt_d);
   assign beat     = (do_load | do_adv)
                     & (state_d != sram_cmd_pkg::st_idle);
   assign is_write = (state_d == sram_cmd_pkg::st_write);

   // Beat taken on this edge waits one qualified edge for its data
   assign stage_d.write   = is_write;
   assign stage_d.addr    = {upper_d, beat_low};
   assign stage_d.lane_we = is_write ? ~lane_write_select_n
                            : sram_cmd_pkg::LANES_NONE;
   assign stage_d.data    = sram_cmd_pkg::DATA_ZERO;
   assign stage_d.parity  = sram_cmd_pkg::PAR_ZERO;
   assign stage_valid_d   = qual ? beat : stage_valid_q;

   // Driver window opens only for a read that follows a live cycle
   assign read_window_d = qual ?
                          ((state_d == sram_cmd_pkg::st_read)
                           & (state_q != sram_cmd_pkg::st_idle))
                          : read_window_q;

   // ***************************************************************
   // Data phase and hand-off
   // ***************************************************************
   // Byte and its parity share one lane select; others go as zero
   assign push_word.write   = stage_q.write;
   assign push_word.addr    = stage_q.addr;
   assign push_word.lane_we = stage_q.lane_we;
   genvar g;
   for (g = 0; g < sram_cmd_pkg::LANES; g++) begin : g_lane
      assign push_word.data[g*sram_cmd_pkg::LANE_W +: sram_cmd_pkg::LANE_W]
         = stage_q.lane_we[g] ?
           dq_in[g*sram_cmd_pkg::LANE_W +: sram_cmd_pkg::LANE_W]
           : 8'h00;
      assign push_word.parity[g] = stage_q.lane_we[g]
                                   & parity_lane_in[g];
   end
   // Controller must hold the qualifier high while cmd_ready is low
   assign push = qual & stage_valid_q & buf_ready;

   // ***************************************************************
   // Registers
   // ***************************************************************
   // Strap is caught during reset and then held for the whole run
   always_ff @(posedge clock) begin
      if (rst) begin
         order_q <= burst_order_strap;
      end
   end

   // Command and burst state
   always_ff @(posedge clock) begin
      if (rst) begin
         state_q       <= sram_cmd_pkg::st_idle;
         upper_q       <= sram_cmd_pkg::UPPER_ZERO;
         start_q       <= sram_cmd_pkg::CNT_ZERO;
         cnt_q         <= sram_cmd_pkg::CNT_ZERO;
         stage_q       <= sram_cmd_pkg::ACCESS_NONE;
         stage_valid_q <= 1'h0;
         read_window_q <= 1'h0;
      end else begin
         state_q       <= state_d;
         upper_q       <= upper_d;
         start_q       <= start_d;
         cnt_q         <= cnt_d;
         stage_valid_q <= stage_valid_d;
         read_window_q <= read_window_d;
         if (qual) begin
            stage_q <= stage_d;
         end
      end
   end

   // Read return and drivers; enable also drops with the enable pin
   always_ff @(posedge clock) begin
      if (rst) begin
         dq_out          <= sram_cmd_pkg::DATA_ZERO;
         parity_lane_out <= sram_cmd_pkg::PAR_ZERO;
         dq_oe           <= 1'h0;
      end else begin
         if (rsp_valid) begin
            dq_out          <= rsp_data;
            parity_lane_out <= rsp_parity;
         end
         dq_oe <= read_window_d & ~output_enable_n;
      end
   end

   // ***************************************************************
   // Buffer toward storage
   // ***************************************************************
   two_slot_buffer #(.WIDTH(ACC_W)) u_buf (
      .clock     (clock),
      .rst       (rst),
      .in_valid  (push),
      .in_ready  (buf_ready),
      .in_data   (push_word),
      .out_valid (acc_valid),
      .out_ready (acc_ready),
      .out_data  (buf_out)
   );
   assign acc_word  = sram_cmd_pkg::access_s'(buf_out);
   assign cmd_ready = buf_ready;

   // ***************************************************************
   // Checks
   // ***************************************************************
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);

   chk_addr_load: assert property (do_load & selected |=>
      stage_q.addr == {$past(addr_high), $past(pin_low)})
      else $error("Loaded address not taken from pins");
   chk_lane_gate: assert property (do_load & selected
      & write_strobe_n |=> stage_q.lane_we == sram_cmd_pkg::LANES_NONE)
      else $error("Lane enables seen on a read");
   chk_lane_map: assert property (push |->
      ((push_word.data[7:0] == 8'h00) || push_word.lane_we[0])
      && (push_word.parity[0] -> push_word.lane_we[0]))
      else $error("Unselected lane carried data");
   chk_write_strobe: assert property (do_load & selected
      & ~write_strobe_n |=>
      state_q == sram_cmd_pkg::st_write ##0 stage_q.write)
      else $error("Write strobe not taken");
   chk_burst_step: assert property (do_adv |=>
      cnt_q == $past(cnt_q) + 2'h1 && upper_q == $past(upper_q))
      else $error("Burst counter did not step");
   chk_hold_unqual: assert property (clock_qualifier_n |=>
      state_q == $past(state_q) && cnt_q == $past(cnt_q)
      && stage_valid_q == $past(stage_valid_q))
      else $error("State moved on an unqualified edge");
   chk_select_decode: assert property (do_load & ~selected |=>
      state_q == sram_cmd_pkg::st_idle ##1 !dq_oe)
      else $error("Deselect not honoured");
   chk_order_use: assert property (stage_valid_q |->
      stage_q.addr[1:0] == ((order_q == sram_cmd_pkg::ORDER_INTERLEAVED)
      ? ($past(start_d) ^ $past(cnt_d)) : ($past(start_d) + $past(cnt_d)))
      || $past(clock_qualifier_n))
      else $error("Burst order not applied");
   chk_oe_mask: assert property (dq_oe |-> read_window_q
      && $past(state_q) != sram_cmd_pkg::st_idle)
      else $error("Drivers on outside a read window");

   cov_write_burst: cover property (do_load & selected & ~write_strobe_n
      ##1 do_adv ##1 do_adv);
   cov_read_drive: cover property (dq_oe);
   cov_stall: cover property (acc_valid & ~acc_ready & ~cmd_ready);
   cov_suspend: cover property (stage_valid_q & clock_qualifier_n);

endmodule

`default_nettype wire

// ---- rtl/sram_cmd_pkg.sv ----
// Shared constants, states and carriers of the burst memory command port
`default_nettype none

package sram_cmd_pkg;

   // ***************************************************************
   // Widths of the widest organisation
   // ***************************************************************
   localparam int ADDR_W  = 20;
   localparam int UPPER_W = 18;
   localparam int LOW_W   = 2;
   localparam int LANES   = 8;
   localparam int LANE_W  = 8;
   localparam int DATA_W  = LANES * LANE_W;

   // ***************************************************************
   // Reset and step values
   // ***************************************************************
   localparam logic [LOW_W-1:0]   CNT_ZERO   = 2'h0;
   localparam logic [LOW_W-1:0]   CNT_STEP   = 2'h1;
   localparam logic [LANES-1:0]   LANES_NONE = 8'h00;
   localparam logic [DATA_W-1:0]  DATA_ZERO  = 64'h0;
   localparam logic [LANES-1:0]   PAR_ZERO   = 8'h00;
   localparam logic [UPPER_W-1:0] UPPER_ZERO = 18'h0;
   localparam logic               ORDER_INTERLEAVED = 1'h1;

   // Access state: deselected, reading or writing
   typedef enum logic [2:0] {
      st_idle  = 3'h1,
      st_read  = 3'h2,
      st_write = 3'h4
   } access_state_e;

   // One access handed to the storage behind the port
   typedef struct packed {
      logic               write;
      logic [ADDR_W-1:0]  addr;
      logic [LANES-1:0]   lane_we;
      logic [DATA_W-1:0]  data;
      logic [LANES-1:0]   parity;
   } access_s;

   localparam access_s ACCESS_NONE = '{1'h0, 20'h0, 8'h00, 64'h0, 8'h00};

endpackage

`default_nettype wire

// ---- rtl/two_slot_buffer.sv ----
// Two-entry buffer with valid and ready on both sides, registered outputs
`timescale 1ns/10ps
`default_nettype none

module two_slot_buffer #(
   parameter int WIDTH = 8
) (
   input  wire logic             clock,
   input  wire logic             rst,
   input  wire logic             in_valid,
   output var  logic             in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   output var  logic             out_valid,
   input  wire logic             out_ready,
   output var  logic [WIDTH-1:0] out_data
);

   logic             skid_valid_q;
   logic [WIDTH-1:0] skid_q;
   logic             drain;
   logic             push;

   // Head slot may be refilled when empty or being taken
   assign drain = out_ready | ~out_valid;
   assign push  = in_valid & in_ready;

   // Second slot catches a word while the drain side stalls
   always_ff @(posedge clock) begin
      if (rst) begin
         out_valid    <= 1'h0;
         skid_valid_q <= 1'h0;
         in_ready     <= 1'h1;
         out_data     <= '0;
         skid_q       <= '0;
      end else begin
         if (drain) begin
            if (skid_valid_q) begin
               out_data     <= skid_q;
               out_valid    <= 1'h1;
               skid_valid_q <= 1'h0;
               in_ready     <= 1'h1;
            end else begin
               out_valid <= push;
               if (push) begin
                  out_data <= in_data;
               end
            end
         end else if (push) begin
            skid_q       <= in_data;
            skid_valid_q <= 1'h1;
            in_ready     <= 1'h0; // Full: refuse until the head drains
         end
      end
   end

endmodule

`default_nettype wire

// ---- dv/sram_ctrl_model.sv ----
// Memory controller model driving the command pins of the burst port
`timescale 1ns/10ps
`default_nettype none

module sram_ctrl_model (
   input  wire logic                             clock,
   input  wire logic                             cmd_ready,
   output var  logic [sram_cmd_pkg::UPPER_W-1:0] addr_high,
   output var  logic                             addr_bit_one,
   output var  logic                             addr_bit_zero,
   output var  logic                             write_strobe_n,
   output var  logic [sram_cmd_pkg::LANES-1:0]   lane_write_select_n,
   output var  logic                             advance_or_load,
   output var  logic                             clock_qualifier_n,
   output var  logic                             chip_select_one_n,
   output var  logic                             chip_select_two,
   output var  logic                             chip_select_three_n,
   output var  logic [sram_cmd_pkg::DATA_W-1:0]  dq_in,
   output var  logic [sram_cmd_pkg::LANES-1:0]   parity_lane_in
);
   // ****************************************
   // Select codes: 0 selects, 1..3 each miss one select
   // ****************************************
   localparam logic [11:0] SELS = 12'h632; // Codes 3..0: 011 000 110 010
   logic [63:0] next_d = 64'h0;
   logic [7:0]  next_p = 8'h00;
   logic        burst_wr = 1'b0;

   // Quiet bus, qualifier high, until the first beat
   initial begin
      {addr_high, addr_bit_one, addr_bit_zero} = 20'h0;
      write_strobe_n = 1'b1;
      lane_write_select_n = 8'hff;
      advance_or_load = 1'b0;
      clock_qualifier_n = 1'b1;
      {chip_select_one_n, chip_select_two, chip_select_three_n} = 3'h6;
      dq_in = 64'h0;
      parity_lane_in = 8'h00;
   end

   // One qualified edge; a full port is held off with the qualifier high
   task automatic beat(input logic [1:0] cs, input logic we_n,
                       input logic adv, input logic [19:0] a,
                       input logic [7:0] sel_n, input logic [63:0] d,
                       input logic [7:0] p);
      @(posedge clock);
      #1;
      while (cmd_ready !== 1'b1) begin
         clock_qualifier_n = 1'b1;
         @(posedge clock);
         #1;
      end
      {addr_high, addr_bit_one, addr_bit_zero} = a;
      write_strobe_n = we_n;
      lane_write_select_n = sel_n;
      advance_or_load = adv;
      {chip_select_one_n, chip_select_two, chip_select_three_n} =
         SELS[cs*3 +: 3];
      // Data of the previous write beat; otherwise the bus shows junk
      dq_in = burst_wr ? next_d : ~dq_in;
      parity_lane_in = burst_wr ? next_p : ~parity_lane_in;
      if (!adv)
         burst_wr = (cs == 2'h0) && !we_n;
      next_d = d;
      next_p = p;
      clock_qualifier_n = 1'b0;
   endtask

   // Suspended cycles: other pins toggle to show they are not taken
   task automatic idle(input int n);
      repeat (n) begin
         @(posedge clock);
         #1;
         clock_qualifier_n = 1'b1;
         write_strobe_n = ~write_strobe_n;
         advance_or_load = ~advance_or_load;
         addr_high = ~addr_high;
      end
   endtask
endmodule

`default_nettype wire

// ---- dv/sync_burst_sram_cmd_port_test.sv ----
// Self-checking bench of the burst memory command port
`timescale 1ns/10ps
`default_nettype none

`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin bad_count++; \
   $display("BAD %0t got %h want %h", $time, g, e); end end

module sync_burst_sram_cmd_port_test;
   // ****************************************
   // Stimulus, model and design
   // ****************************************
   logic clock = 1'b0;
   logic rst = 1'b1;
   logic output_enable_n = 1'b1;
   logic burst_order_strap = 1'b1;
   logic rsp_valid = 1'b0;
   logic [63:0] rsp_data = 64'h0;
   logic [7:0] rsp_parity = 8'h00;
   logic acc_ready = 1'b1;
   logic [17:0] addr_high;
   logic adr_one, adr_zero, we_n, adv, qual_n, cs1_n, cs2, cs3_n;
   logic cmd_ready, dq_oe, acc_valid;
   logic [7:0] lane_sel_n, par_in, parity_lane_out;
   logic [63:0] dq_in, dq_out;
   sram_cmd_pkg::access_s acc_word;
   sram_cmd_pkg::access_s got[$];
   int bad_count = 0;
   int num_checks = 0;

   sram_ctrl_model i_ctrl (.clock(clock), .cmd_ready(cmd_ready),
      .addr_high(addr_high), .addr_bit_one(adr_one),
      .addr_bit_zero(adr_zero),
      .write_strobe_n(we_n), .lane_write_select_n(lane_sel_n),
      .advance_or_load(adv), .clock_qualifier_n(qual_n),
      .chip_select_one_n(cs1_n), .chip_select_two(cs2),
      .chip_select_three_n(cs3_n), .dq_in(dq_in), .parity_lane_in(par_in));

   sync_burst_sram_cmd_port i_dut (.clock(clock), .rst(rst),
      .addr_high(addr_high), .addr_bit_one(adr_one),
      .addr_bit_zero(adr_zero),
      .write_strobe_n(we_n), .lane_write_select_n(lane_sel_n),
      .advance_or_load(adv), .clock_qualifier_n(qual_n),
      .chip_select_one_n(cs1_n), .chip_select_two(cs2),
      .chip_select_three_n(cs3_n), .output_enable_n(output_enable_n),
      .burst_order_strap(burst_order_strap), .dq_in(dq_in),
      .parity_lane_in(par_in), .dq_out(dq_out),
      .parity_lane_out(parity_lane_out), .dq_oe(dq_oe),
      .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_parity(rsp_parity),
      .acc_valid(acc_valid), .acc_ready(acc_ready), .acc_word(acc_word),
      .cmd_ready(cmd_ready));

   // 100 MHz clock
   always #5 clock = ~clock;

   // Words accepted by the storage side, in order
   always @(posedge clock) begin
      if (acc_valid === 1'b1 && acc_ready === 1'b1)
         got.push_back(acc_word);
   end

   // Unselected lanes read back as zero
   function automatic logic [63:0] keep(input logic [63:0] d,
                                        input logic [7:0]  on);
      for (int g = 0; g < 8; g++)
         if (!on[g])
            d[g*8 +: 8] = 8'h00;
      return d;
   endfunction

   task automatic pop_chk(input sram_cmd_pkg::access_s e);
      sram_cmd_pkg::access_s w;
      // An empty queue yields the inverse so the compare must fail
      w = (got.size() > 0) ? got.pop_front() : sram_cmd_pkg::access_s'(~e);
      `CHK(w, e)
   endtask

   task automatic settle();
      repeat (4) @(posedge clock);
      #1;
   endtask

   task automatic do_reset(input logic strap);
      rst = 1'b1;
      burst_order_strap = strap;
      repeat (6) @(posedge clock);
      #1;
      rst = 1'b0;
   endtask

   // ****************************************
   // Scenarios
   // ****************************************
   // One write with half the lanes, one read, then deselect
   task automatic t_write_read();
      logic [63:0] d;
      d = 64'h1122334455667788;
      got.delete();
      i_ctrl.beat(2'h0, 1'b0, 1'b0, 20'habcd5, 8'h5a, d, 8'h3c);
      i_ctrl.beat(2'h0, 1'b1, 1'b0, 20'h00002, 8'h00, d, 8'h00);
      i_ctrl.beat(2'h3, 1'b1, 1'b0, 20'h0, 8'hff, d, 8'h00);
      settle();
      pop_chk('{1'b1, 20'habcd5, 8'ha5, keep(d, 8'ha5), 8'h24});
      pop_chk('{1'b0, 20'h00002, 8'h00, 64'h0, 8'h00});
      $display("write and read done");
   endtask

   // Four beats, suspended mid-burst; lows holds expected low address bits
   task automatic t_burst(input logic       strap,
                          input logic [1:0] s,
                          input logic [7:0] lows);
      sram_cmd_pkg::access_s e;
      do_reset(strap);
      got.delete();
      for (int i = 0; i < 4; i++) begin
         i_ctrl.beat(2'h0, 1'b0, i != 0, {18'h2a5a5, s}, 8'h00,
                     64'(i + 1), 8'(i));
         if (i == 1)
            i_ctrl.idle(2);
      end
      i_ctrl.beat(2'h3, 1'b1, 1'b0, 20'h0, 8'hff, 64'h0, 8'h00);
      settle();
      for (int i = 0; i < 4; i++) begin
         e = '{1'b1, {18'h2a5a5, lows[i*2 +: 2]}, 8'hff, 64'(i + 1), 8'(i)};
         pop_chk(e);
      end
      $display("burst done");
   endtask

   // Each missing select and an advance after deselect must add no word
   task automatic t_desel();
      got.delete();
      for (int c = 1; c < 4; c++)
         i_ctrl.beat(2'(c), 1'b0, 1'b0, 20'h00011, 8'h00, 64'h5, 8'h01);
      i_ctrl.beat(2'h0, 1'b0, 1'b1, 20'h00022, 8'h00, 64'h6, 8'h02);
      i_ctrl.beat(2'h3, 1'b1, 1'b0, 20'h0, 8'hff, 64'h0, 8'h00);
      settle();
      `CHK(got.size(), 0)
      $display("deselect done");
   endtask

   // Storage stalls; the model must hold off while the buffer is full
   task automatic t_stall();
      sram_cmd_pkg::access_s e;
      got.delete();
      acc_ready = 1'b0;
      fork
         begin
            for (int i = 0; i < 6; i++)
               i_ctrl.beat(2'h0, 1'b0, 1'b0, 20'h00100 + 20'(i), 8'h00,
                           64'(i), 8'h00);
            i_ctrl.beat(2'h3, 1'b1, 1'b0, 20'h0, 8'hff, 64'h0, 8'h00);
         end
         begin
            repeat (12) @(posedge clock);
            #1;
            `CHK(cmd_ready, 1'b0)
            acc_ready = 1'b1;
         end
      join
      settle();
      `CHK(got.size(), 6)
      for (int i = 0; i < 6; i++) begin
         e = '{1'b1, 20'h00100 + 20'(i), 8'hff, 64'(i), 8'h00};
         pop_chk(e);
      end
      $display("stall done");
   endtask

   // Drivers: off after deselect, on mid-read, off for write and deselect
   task automatic t_oe();
      output_enable_n = 1'b0;
      i_ctrl.beat(2'h0, 1'b1, 1'b0, 20'h00040, 8'h00, 64'h0, 8'h00);
      i_ctrl.idle(3);
      `CHK(dq_oe, 1'b0)
      i_ctrl.beat(2'h0, 1'b1, 1'b1, 20'h00040, 8'h00, 64'h0, 8'h00);
      i_ctrl.idle(3);
      `CHK(dq_oe, 1'b1)
      rsp_data = 64'h0bad_cafe_1234_5678;
      rsp_parity = 8'h5a;
      rsp_valid = 1'b1;
      @(posedge clock);
      #1;
      rsp_valid = 1'b0;
      @(posedge clock);
      #1;
      `CHK({dq_out, parity_lane_out}, {64'h0bad_cafe_1234_5678, 8'h5a})
      i_ctrl.beat(2'h0, 1'b0, 1'b0, 20'h00050, 8'h00, 64'h7, 8'h00);
      i_ctrl.idle(3);
      `CHK(dq_oe, 1'b0)
      i_ctrl.beat(2'h2, 1'b1, 1'b0, 20'h0, 8'hff, 64'h0, 8'h00);
      i_ctrl.idle(3);
      `CHK(dq_oe, 1'b0)
      $display("output enable done");
   endtask

   task automatic end_of_test();
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   // Main sequence
   initial begin
      do_reset(1'b1);
      t_write_read();
      t_burst(1'b1, 2'h1, 8'hb1);
      t_burst(1'b0, 2'h3, 8'h93);
      t_desel();
      t_stall();
      t_oe();
      end_of_test();
   end

   // Watchdog: the tests need well under a thousand cycles
   initial begin
      #50000;
      bad_count++;
      $display("BAD %0t watchdog expired", $time);
      end_of_test();
   end
endmodule

`undef CHK
`default_nettype wire
